// ### sbc_fault_status_registers.sv
`timescale 1ns/1ps
module sbc_fault_status_registers #(
   parameter int TX_ENABLE_CYCLES = sbc_pkg::TX_ENABLE_CYCLES
) (
   input  wire logic                                            ref_clk,
   input  wire logic                                            reset_n,
   input  wire logic                                            spi_sclk,
   input  wire logic                                            spi_cs_n,
   input  wire logic                                            spi_mosi,
   output logic                                                 spi_miso,
   output logic                                                 spi_miso_oe,
   input  wire logic                                            severe_overheat_in,
   input  wire logic                                            overheat_shutdown_in,
   input  wire logic                                            heat_prewarning_in,
   input  wire logic                                            reset_pin_stuck_high_in,
   input  wire logic                                            can_supply_low_in,
   input  wire sbc_pkg::trx_monitor_s [sbc_pkg::NUM_TRX-1:0]    trx_mon,
   input  wire logic [sbc_pkg::NUM_TRX-1:0]                     trx_off_or_wake,
   input  wire sbc_pkg::can_mode_e                              can_mode,
   input  wire logic                                            wake_pattern_seen,
   input  wire logic                                            restart_after_failure,
   input  wire logic                                            wake_from_sleep,
   input  wire logic                                            failsafe_input_error,
   input  wire logic                                            watchdog_miss,
   input  wire logic                                            watchdog_good_trigger,
   input  wire logic                                            cfg_fail_on_first,
   input  wire logic                                            fail_outputs_on,
   output logic                                                 enter_failsafe,
   output logic                                                 fail_output_request,
   output logic [sbc_pkg::NUM_TRX-1:0]                          trx_tx_enable,
   output logic                                                 can_uv_compare_enable
);

   localparam int PIN_W = 5 * sbc_pkg::NUM_TRX + 5;
   localparam int CNT_W = $clog2(TX_ENABLE_CYCLES + 1);

   function automatic logic sticky(input logic flag, input logic set, input logic clr);
      sticky = set | (flag & ~clr);
   endfunction

   function automatic logic [7:0] byte_at(input logic [6:0] addr, input logic [31:0] regs);
      byte_at = 8'h00;
      if (addr >= sbc_pkg::ADDR_THERMAL && addr <= sbc_pkg::ADDR_BUS_B)
      begin
         byte_at = regs[8 * (addr - sbc_pkg::ADDR_THERMAL) +: 8];
      end
   endfunction

   logic [PIN_W-1:0]                        pin_meta;
   logic [PIN_W-1:0]                        pin_sync;
   logic                                    severe_last;
   logic                                    cs_meta;
   logic                                    cs_sync;
   logic                                    cs_last;
   sbc_pkg::trx_monitor_s [sbc_pkg::NUM_TRX-1:0] trx_now;
   logic                                    severe_now;
   logic                                    overheat_now;
   logic                                    prewarn_now;
   logic                                    reset_stuck_now;
   logic                                    uv_now;

   logic                                    new_frame;
   logic [4:0]                              bit_count;
   logic [15:0]                             rx_word;
   logic [3:0]                              rx_index;
   logic [15:0]                             tx_word;

   logic [31:0]                             snapshot;
   logic [31:0]                             live;
   logic                                    frame_start;
   logic                                    frame_end;
   logic                                    frame_good;
   logic [sbc_pkg::NUM_STATUS_REGS-1:0]     clr_hit;
   logic [7:0]                              clr_therm;
   logic [7:0]                              clr_dev;
   logic [7:0]                              clr_bus_a;
   logic [7:0]                              clr_bus_b;

   logic                                    severe_flag;
   logic                                    overheat_flag;
   logic                                    prewarn_flag;
   logic [1:0]                              restart_cause;
   logic                                    reset_stuck_flag;
   logic                                    fsi_flag;
   logic [1:0]                              wd_count;
   logic                                    cmd_err_flag;
   logic                                    fo_flag;
   logic                                    can_uv_flag;
   logic [1:0]                              chan_code [sbc_pkg::NUM_TRX];
   logic [1:0]                              chan_snap [sbc_pkg::NUM_TRX];
   logic [sbc_pkg::NUM_TRX-1:0]             chan_clr;
   logic [sbc_pkg::NUM_TRX-1:0]             any_tsd;
   logic [sbc_pkg::NUM_TRX-1:0]             blk_tsd;
   logic [sbc_pkg::NUM_TRX-1:0]             blk_tx;
   logic [sbc_pkg::NUM_TRX-1:0]             blk_line;
   logic                                    blk_uv;
   logic [CNT_W-1:0]                        en_count [sbc_pkg::NUM_TRX];

   assign trx_now         = pin_sync[PIN_W-1:5];
   assign uv_now          = pin_sync[4];
   assign reset_stuck_now = pin_sync[3];
   assign severe_now      = pin_sync[2];
   assign overheat_now    = pin_sync[1];
   assign prewarn_now     = pin_sync[0];

   // Monitor pins are asynchronous to ref_clk
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_meta    <= '0;
         pin_sync    <= '0;
         severe_last <= 1'b0;
      end
      else
      begin
         pin_meta    <= {trx_mon, can_supply_low_in, reset_pin_stuck_high_in, severe_overheat_in,
                         overheat_shutdown_in, heat_prewarning_in};
         pin_sync    <= pin_meta;
         severe_last <= severe_now;
      end
   end

   // Serial link domain; new_frame is forced while select is high
   always_ff @(posedge spi_sclk or posedge spi_cs_n or negedge reset_n)
   begin
      if (!reset_n)
         new_frame <= 1'b1;
      else if (spi_cs_n)
         new_frame <= 1'b1;
      else
         new_frame <= 1'b0;
   end

   assign rx_index = new_frame ? 4'h0 : bit_count[3:0];

   always_ff @(posedge spi_sclk or negedge reset_n)
   begin
      if (!reset_n)
         bit_count <= 5'h00;
      else if (new_frame)
         bit_count <= 5'h01;
      else if (bit_count != sbc_pkg::COUNT_MAX)
         bit_count <= bit_count + 5'h01;
   end

   always_ff @(posedge spi_sclk or negedge reset_n)
   begin
      if (!reset_n)
         rx_word <= 16'h0000;
      else if (new_frame || bit_count < sbc_pkg::CMD_COUNT)
         rx_word[rx_index] <= spi_mosi;
   end

   // Snapshot is loaded at frame start and then frozen for the rest of the frame, so reading it here is safe
   assign tx_word = {byte_at(rx_word[6:0], snapshot), 8'h00};

   always_ff @(negedge spi_sclk or posedge spi_cs_n or negedge reset_n)
   begin
      if (!reset_n)
         spi_miso <= 1'b0;
      else if (spi_cs_n)
         spi_miso <= 1'b0;
      else if (bit_count < sbc_pkg::CMD_COUNT)
         spi_miso <= tx_word[bit_count[3:0]];
      else
         spi_miso <= 1'b0;
   end

   // Frame boundaries seen from ref_clk; link words are quasi-static after select rises
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cs_meta     <= 1'b1;
         cs_sync     <= 1'b1;
         cs_last     <= 1'b1;
         spi_miso_oe <= 1'b0;
      end
      else
      begin
         cs_meta     <= spi_cs_n;
         cs_sync     <= cs_meta;
         cs_last     <= cs_sync;
         spi_miso_oe <= ~cs_sync;
      end
   end

   assign frame_start = cs_last & ~cs_sync;
   assign frame_end   = ~cs_last & cs_sync;
   assign frame_good  = bit_count == sbc_pkg::CMD_COUNT;

   assign live = {1'b0, chan_code[sbc_pkg::CH_LIN4], chan_code[sbc_pkg::CH_LIN3], chan_code[sbc_pkg::CH_LIN2], 1'b0,
                  1'b0, chan_code[sbc_pkg::CH_LIN1], 2'b00, chan_code[sbc_pkg::CH_CAN], can_uv_flag,
                  restart_cause, reset_stuck_flag, fsi_flag, wd_count, cmd_err_flag, fo_flag,
                  5'b00000, severe_flag, overheat_flag, prewarn_flag};

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         snapshot <= '0;
      else if (frame_start)
         snapshot <= live;
   end

   // Only bits the host actually saw are cleared, so later events survive
   genvar r;
   generate
      for (r = 0; r < sbc_pkg::NUM_STATUS_REGS; r++)
      begin : g_clr
         assign clr_hit[r] = frame_end & frame_good & rx_word[sbc_pkg::MODE_BIT] &
                             (rx_word[6:0] == sbc_pkg::ADDR_THERMAL + 7'(r));
      end
   endgenerate

   assign clr_therm = clr_hit[0] ? snapshot[7:0]   : 8'h00;
   assign clr_dev   = clr_hit[1] ? snapshot[15:8]  : 8'h00;
   assign clr_bus_a = clr_hit[2] ? snapshot[23:16] : 8'h00;
   assign clr_bus_b = clr_hit[3] ? snapshot[31:24] : 8'h00;

   // Thermal flags
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         severe_flag    <= 1'b0;
         overheat_flag  <= 1'b0;
         prewarn_flag   <= 1'b0;
         enter_failsafe <= 1'b0;
      end
      else
      begin
         severe_flag    <= sticky(severe_flag, severe_now, clr_therm[sbc_pkg::SEVERE_BIT]);
         overheat_flag  <= sticky(overheat_flag, overheat_now | (|any_tsd),
                                  clr_therm[sbc_pkg::OVERHEAT_BIT]);
         prewarn_flag   <= sticky(prewarn_flag, prewarn_now, clr_therm[sbc_pkg::PREWARN_BIT]);
         enter_failsafe <= severe_now & ~severe_last;
      end
   end

   // Device history
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         restart_cause <= sbc_pkg::RESTART_CLEARED;
      else if (restart_after_failure)
         restart_cause <= sbc_pkg::RESTART_FAILURE;
      else if (wake_from_sleep)
         restart_cause <= sbc_pkg::RESTART_SLEEP;
      else if (clr_hit[1] && snapshot[15:14] == restart_cause)
         restart_cause <= sbc_pkg::RESTART_CLEARED;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reset_stuck_flag <= 1'b0;
         fsi_flag         <= 1'b0;
         cmd_err_flag     <= 1'b0;
         fo_flag          <= 1'b0;
      end
      else
      begin
         reset_stuck_flag <= sticky(reset_stuck_flag, reset_stuck_now, clr_dev[sbc_pkg::RESET_PIN_BIT]);
         fsi_flag         <= sticky(fsi_flag, failsafe_input_error, clr_dev[sbc_pkg::FSI_ERR_BIT]);
         cmd_err_flag     <= sticky(cmd_err_flag, frame_end & ~frame_good, clr_dev[sbc_pkg::CMD_ERR_BIT]);
         fo_flag          <= sticky(fo_flag, fail_output_request | fail_outputs_on,
                                    clr_dev[sbc_pkg::FO_ON_BIT]);
      end
   end

   // Miss beats good trigger in the same cycle; host clears do not touch it
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         wd_count <= sbc_pkg::WD_NONE;
      else if (watchdog_miss)
         wd_count <= (wd_count == sbc_pkg::WD_NONE) ? sbc_pkg::WD_ONE : sbc_pkg::WD_TWO;
      else if (watchdog_good_trigger)
         wd_count <= sbc_pkg::WD_NONE;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         fail_output_request <= 1'b0;
      else
         fail_output_request <= cfg_fail_on_first ? (wd_count != sbc_pkg::WD_NONE)
                                                  : (wd_count == sbc_pkg::WD_TWO);
   end

   // CAN supply undervoltage
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         can_uv_compare_enable <= 1'b0;
         can_uv_flag           <= 1'b0;
         blk_uv                <= 1'b0;
      end
      else
      begin
         can_uv_compare_enable <= (can_mode == sbc_pkg::CAN_NORMAL) || (can_mode == sbc_pkg::CAN_RECEIVE_ONLY) ||
                                  (can_mode == sbc_pkg::CAN_WAKE_CAPABLE && wake_pattern_seen);
         can_uv_flag           <= sticky(can_uv_flag, can_uv_compare_enable & uv_now,
                                         clr_bus_a[sbc_pkg::CAN_UV_BIT]);
         blk_uv                <= sticky(blk_uv, can_uv_compare_enable & uv_now, ~uv_now);
      end
   end

   assign chan_snap[sbc_pkg::CH_CAN]  = snapshot[17:16];
   assign chan_snap[sbc_pkg::CH_LIN1] = snapshot[22:21];
   assign chan_snap[sbc_pkg::CH_LIN2] = snapshot[26:25];
   assign chan_snap[sbc_pkg::CH_LIN3] = snapshot[28:27];
   assign chan_snap[sbc_pkg::CH_LIN4] = snapshot[30:29];
   assign chan_clr = {clr_hit[3], clr_hit[3], clr_hit[3], clr_hit[2], clr_hit[2]};

   genvar c;
   generate
      for (c = 0; c < sbc_pkg::NUM_TRX; c++)
      begin : g_trx
         logic blocked;
         logic recover_tx;
         logic recover_line;

         assign any_tsd[c]   = trx_now[c].tsd;
         assign recover_tx   = trx_now[c].tx_high | trx_off_or_wake[c];
         assign recover_line = trx_now[c].line_recessive | trx_off_or_wake[c];
         assign blocked      = blk_tsd[c] | blk_tx[c] | blk_line[c] | ((c == sbc_pkg::CH_CAN) && blk_uv);

         // Worst fault wins when several are present together
         always_ff @(posedge ref_clk or negedge reset_n)
         begin
            if (!reset_n)
               chan_code[c] <= sbc_pkg::FAULT_NONE;
            else if (trx_now[c].line_stuck)
               chan_code[c] <= sbc_pkg::FAULT_LINE;
            else if (trx_now[c].tx_stuck)
               chan_code[c] <= sbc_pkg::FAULT_TX;
            else if (trx_now[c].tsd)
               chan_code[c] <= sbc_pkg::FAULT_TSD;
            else if (chan_clr[c] && chan_snap[c] == chan_code[c])
               chan_code[c] <= sbc_pkg::FAULT_NONE;
         end

         always_ff @(posedge ref_clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               blk_tsd[c]  <= 1'b0;
               blk_tx[c]   <= 1'b0;
               blk_line[c] <= 1'b0;
            end
            else
            begin
               blk_tsd[c]  <= sticky(blk_tsd[c], trx_now[c].tsd, 1'b1);
               blk_tx[c]   <= sticky(blk_tx[c], trx_now[c].tx_stuck, recover_tx);
               blk_line[c] <= sticky(blk_line[c], trx_now[c].line_stuck, recover_line);
            end
         end

         // Transmitter comes back only after tx input has been high for the full time
         always_ff @(posedge ref_clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               en_count[c]      <= '0;
               trx_tx_enable[c] <= 1'b0;
            end
            else if (blocked || !trx_now[c].tx_high)
            begin
               en_count[c]      <= '0;
               trx_tx_enable[c] <= 1'b0;
            end
            else if (en_count[c] != CNT_W'(TX_ENABLE_CYCLES))
            begin
               en_count[c]      <= en_count[c] + CNT_W'(1);
               trx_tx_enable[c] <= 1'b0;
            end
            else
               trx_tx_enable[c] <= 1'b1;
         end
      end
   endgenerate

endmodule

// ### sbc_pkg.sv
package sbc_pkg;

   localparam logic [6:0] ADDR_THERMAL    = 7'h42;
   localparam logic [6:0] ADDR_DEVICE     = 7'h43;
   localparam logic [6:0] ADDR_BUS_A      = 7'h44;
   localparam logic [6:0] ADDR_BUS_B      = 7'h45;
   localparam int         NUM_STATUS_REGS = 4;

   localparam logic [7:0] RESET_VALUE     = 8'h00;
   localparam logic [7:0] THERMAL_MASK    = 8'h07;
   localparam logic [7:0] BUS_A_MASK      = 8'h67;
   localparam logic [7:0] BUS_B_MASK      = 8'h7e;

   localparam int SEVERE_BIT    = 2;
   localparam int OVERHEAT_BIT  = 1;
   localparam int PREWARN_BIT   = 0;
   localparam int RESTART_LSB   = 6;
   localparam int RESET_PIN_BIT = 5;
   localparam int FSI_ERR_BIT   = 4;
   localparam int WD_CNT_LSB    = 2;
   localparam int CMD_ERR_BIT   = 1;
   localparam int FO_ON_BIT     = 0;
   localparam int LIN_HI_LSB    = 5;
   localparam int LIN_MID_LSB   = 3;
   localparam int LIN_LO_LSB    = 1;
   localparam int CAN_UV_BIT    = 0;

   localparam logic [1:0] FAULT_NONE = 2'h0;
   localparam logic [1:0] FAULT_TSD  = 2'h1;
   localparam logic [1:0] FAULT_TX   = 2'h2;
   localparam logic [1:0] FAULT_LINE = 2'h3;

   localparam logic [1:0] RESTART_CLEARED = 2'h0;
   localparam logic [1:0] RESTART_FAILURE = 2'h1;
   localparam logic [1:0] RESTART_SLEEP   = 2'h2;

   localparam logic [1:0] WD_NONE = 2'h0;
   localparam logic [1:0] WD_ONE  = 2'h1;
   localparam logic [1:0] WD_TWO  = 2'h2;

   localparam int         CMD_BITS  = 16;
   localparam int         MODE_BIT  = 7;
   localparam int         DATA_LSB  = 8;
   localparam logic [4:0] CMD_COUNT = 5'h10;
   localparam logic [4:0] COUNT_MAX = 5'h1f;

   localparam int NUM_TRX = 5;
   localparam int CH_CAN  = 0;
   localparam int CH_LIN1 = 1;
   localparam int CH_LIN2 = 2;
   localparam int CH_LIN3 = 3;
   localparam int CH_LIN4 = 4;

   localparam int REF_CLK_MHZ         = 100;
   localparam int TX_ENABLE_TIME_NS   = 10000;
   localparam int TX_ENABLE_CYCLES    = (TX_ENABLE_TIME_NS * REF_CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      CAN_OFF,
      CAN_WAKE_CAPABLE,
      CAN_RECEIVE_ONLY,
      CAN_NORMAL
   } can_mode_e;

   typedef struct packed {
      logic tx_high;
      logic tsd;
      logic tx_stuck;
      logic line_stuck;
      logic line_recessive;
   } trx_monitor_s;

endpackage

// ### sbc_fault_status_registers_assertions.sv
`timescale 1ns/1ps
module sbc_fault_status_checker #(
   parameter int TX_ENABLE_CYCLES = 8
) (
   input wire logic                                         ref_clk,
   input wire logic                                         reset_n,
   input wire logic                                         spi_cs_n,
   input wire logic                                         spi_miso,
   input wire logic                                         spi_miso_oe,
   input wire logic                                         severe_overheat_in,
   input wire logic                                         can_supply_low_in,
   input wire sbc_pkg::trx_monitor_s [sbc_pkg::NUM_TRX-1:0] trx_mon,
   input wire sbc_pkg::can_mode_e                           can_mode,
   input wire logic                                         wake_pattern_seen,
   input wire logic                                         watchdog_miss,
   input wire logic                                         watchdog_good_trigger,
   input wire logic                                         cfg_fail_on_first,
   input wire logic                                         enter_failsafe,
   input wire logic                                         fail_output_request,
   input wire logic [sbc_pkg::NUM_TRX-1:0]                  trx_tx_enable,
   input wire logic                                         can_uv_compare_enable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Raw pin count; the design's synced count lags it, so this bound is safe
   int unsigned hi_cnt;
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n || !trx_mon[1].tx_high)
         hi_cnt <= 0;
      else if (hi_cnt < 1000)
         hi_cnt <= hi_cnt + 1;
   end
   a_failsafe_entry: assert property ($rose(severe_overheat_in) |-> ##[2:4] enter_failsafe)
      else $error("failsafe request missing");
   a_failsafe_pulse: assert property (enter_failsafe |=> !enter_failsafe)
      else $error("failsafe request too long");
   a_cmp_off: assert property ((can_mode == sbc_pkg::CAN_OFF)[*2] |-> !can_uv_compare_enable)
      else $error("comparator on while off");
   a_cmp_active: assert property ((can_mode inside {sbc_pkg::CAN_NORMAL, sbc_pkg::CAN_RECEIVE_ONLY})[*2]
      |-> can_uv_compare_enable) else $error("comparator off while active");
   a_cmp_wake_gate: assert property ((can_mode == sbc_pkg::CAN_WAKE_CAPABLE && !wake_pattern_seen)[*2]
      |-> !can_uv_compare_enable) else $error("comparator on before wake pattern");
   a_uv_blocks_can: assert property ((can_supply_low_in && can_mode == sbc_pkg::CAN_NORMAL)[*6]
      |-> !trx_tx_enable[0]) else $error("can transmitter on in undervoltage");
   a_enable_wait: assert property (trx_tx_enable[1] |-> hi_cnt >= TX_ENABLE_CYCLES)
      else $error("transmitter enabled too early");
   a_tsd_blocks: assert property ((trx_mon[2].tsd)[*5] |-> !trx_tx_enable[2])
      else $error("transmitter on during overheat");
   a_wd_request: assert property (watchdog_miss && cfg_fail_on_first |-> ##[1:3] fail_output_request)
      else $error("fail output request missing");
   a_wd_release: assert property (watchdog_good_trigger && !watchdog_miss |-> ##[1:3] !fail_output_request)
      else $error("fail output request kept");
   a_miso_idle: assert property (spi_cs_n |-> !spi_miso)
      else $error("miso driven while deselected");
   a_oe_idle: assert property (spi_cs_n[*4] |-> !spi_miso_oe)
      else $error("miso enable while deselected");
endmodule

bind sbc_fault_status_registers sbc_fault_status_checker #(.TX_ENABLE_CYCLES(TX_ENABLE_CYCLES))
   sbc_fault_status_checker_i (.*);

// ### spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso
);
   initial
   begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // Bit counts other than 16 make a refused frame on purpose
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      spi_cs_n = 1'b0;
      for (int k = 0; k < n; k++)
      begin
         spi_mosi = tx[k];
         #62.5;
         rx[k] = spi_miso;
         spi_sclk = 1'b1;
         #62.5;
         spi_sclk = 1'b0;
      end
      #62.5;
      spi_cs_n = 1'b1;
      // No pull on mosi, so the released line shows no stale data
      spi_mosi = ~spi_mosi;
      #200;
   endtask
endmodule

// ### test_sbc_fault_status_registers.sv
`timescale 1ns/1ps
module test_sbc_fault_status_registers;
   localparam int TXE = 8;
   logic ref_clk, reset_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic severe_overheat_in, overheat_shutdown_in, heat_prewarning_in, reset_pin_stuck_high_in, can_supply_low_in;
   sbc_pkg::trx_monitor_s [4:0] trx_mon;
   logic [4:0] trx_off_or_wake, trx_tx_enable;
   sbc_pkg::can_mode_e can_mode;
   logic wake_pattern_seen, restart_after_failure, wake_from_sleep, failsafe_input_error, watchdog_miss;
   logic watchdog_good_trigger, cfg_fail_on_first, fail_outputs_on, enter_failsafe, fail_output_request;
   logic can_uv_compare_enable;
   logic [15:0] rx;
   logic        wd_seen;
   int errors, n_tests;
   sbc_fault_status_registers #(.TX_ENABLE_CYCLES(TXE)) sbc_fault_status_registers_i (.*);
   spi_host_model spi_host_model_i (.*);
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      spi_host_model_i.xfer({8'h00, 1'b0, a}, 16, rx);
      check(rx[15:8], exp);
   endtask
   task automatic clr(input logic [6:0] a);
      spi_host_model_i.xfer({8'h5a, 1'b1, a}, 16, rx);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_thermal;
      {severe_overheat_in, overheat_shutdown_in, heat_prewarning_in} = 3'h7;
      tick(5);
      {severe_overheat_in, overheat_shutdown_in, heat_prewarning_in} = 3'h0;
      tick(5);
      rd(sbc_pkg::ADDR_THERMAL, 8'h07);
      clr(sbc_pkg::ADDR_THERMAL);
      rd(sbc_pkg::ADDR_THERMAL, 8'h00);
   endtask
   task automatic t_device;
      {restart_after_failure, failsafe_input_error, reset_pin_stuck_high_in, fail_outputs_on} = 4'hf;
      tick(1);
      {restart_after_failure, failsafe_input_error} = 2'h0;
      repeat (3)
      begin
         watchdog_miss = 1'b1;
         tick(1);
         watchdog_miss = 1'b0;
         tick(1);
      end
      {reset_pin_stuck_high_in, fail_outputs_on} = 2'h0;
      tick(5);
      rd(sbc_pkg::ADDR_DEVICE, 8'h79);
      check({7'h00, fail_output_request}, 8'h01);
      watchdog_good_trigger = 1'b1;
      tick(1);
      watchdog_good_trigger = 1'b0;
      tick(2);
      check({7'h00, fail_output_request}, 8'h00);
      rd(sbc_pkg::ADDR_DEVICE, 8'h71);
      spi_host_model_i.xfer({8'h00, 1'b1, sbc_pkg::ADDR_DEVICE}, 8, rx);
      rd(sbc_pkg::ADDR_DEVICE, 8'h73);
      clr(sbc_pkg::ADDR_DEVICE);
      rd(sbc_pkg::ADDR_DEVICE, 8'h00);
      wake_from_sleep = 1'b1;
      tick(1);
      wake_from_sleep = 1'b0;
      rd(sbc_pkg::ADDR_DEVICE, 8'h80);
      // Second configuration: fail outputs only after the second miss
      cfg_fail_on_first = 1'b0;
      repeat (2)
      begin
         watchdog_miss = 1'b1;
         tick(1);
         watchdog_miss = 1'b0;
         tick(3);
         check({7'h00, fail_output_request}, {7'h00, wd_seen});
         wd_seen = 1'b1;
      end
      watchdog_good_trigger = 1'b1;
      tick(1);
      watchdog_good_trigger = 1'b0;
      tick(2);
      check({7'h00, fail_output_request}, 8'h00);
      cfg_fail_on_first = 1'b1;
   endtask
   task automatic t_bus;
      int i;
      can_mode = sbc_pkg::CAN_NORMAL;
      trx_mon[0].tx_stuck = 1'b1;
      trx_mon[0].tx_high = 1'b0;
      trx_mon[3].tx_stuck = 1'b1;
      trx_mon[3].tx_high = 1'b0;
      trx_mon[1].line_stuck = 1'b1;
      trx_mon[1].line_recessive = 1'b0;
      trx_mon[4].line_stuck = 1'b1;
      trx_mon[4].line_recessive = 1'b0;
      trx_mon[2].tsd = 1'b1;
      can_supply_low_in = 1'b1;
      tick(8);
      check({3'h0, trx_tx_enable}, 8'h00);
      rd(sbc_pkg::ADDR_BUS_A, 8'h65);
      rd(sbc_pkg::ADDR_BUS_B, 8'h72);
      rd(sbc_pkg::ADDR_THERMAL, 8'h02);
      trx_mon = {5{5'h11}};
      can_supply_low_in = 1'b0;
      for (i = 0; i < 40 && trx_tx_enable !== 5'h1f; i++)
         tick(1);
      check({3'h0, trx_tx_enable}, 8'h1f);
      if (i == 40)
         test_done();
      rd(sbc_pkg::ADDR_BUS_A, 8'h65);
      clr(sbc_pkg::ADDR_BUS_A);
      clr(sbc_pkg::ADDR_BUS_B);
      rd(sbc_pkg::ADDR_BUS_B, 8'h00);
   endtask
   task automatic t_modes;
      for (int m = 0; m < 4; m++)
      begin
         can_mode = sbc_pkg::can_mode_e'(m);
         tick(3);
         check({7'h00, can_uv_compare_enable}, {7'h00, m >= 2});
      end
      can_mode = sbc_pkg::CAN_WAKE_CAPABLE;
      wake_pattern_seen = 1'b1;
      tick(3);
      check({7'h00, can_uv_compare_enable}, 8'h01);
   endtask
   initial
   begin
      errors = 0;
      n_tests = 0;
      reset_n = 1'b0;
      {severe_overheat_in, overheat_shutdown_in, heat_prewarning_in, reset_pin_stuck_high_in} = 4'h0;
      {can_supply_low_in, wake_pattern_seen, restart_after_failure, wake_from_sleep} = 4'h0;
      {failsafe_input_error, watchdog_miss, watchdog_good_trigger, fail_outputs_on} = 4'h0;
      trx_mon = {5{5'h11}};
      trx_off_or_wake = 5'h00;
      can_mode = sbc_pkg::CAN_OFF;
      cfg_fail_on_first = 1'b1;
      wd_seen = 1'b0;
      tick(6);
      reset_n = 1'b1;
      tick(4);
      for (int a = 'h42; a <= 'h46; a++)
         rd(a[6:0], 8'h00);
      t_thermal();
      t_device();
      t_bus();
      t_modes();
      test_done();
   end
endmodule
